/* rtl/irq_bank_pkg.sv */
/*
 * constants for the interrupt flag and enable bank: register indices in the
 * special-purpose data memory, field positions, reset values, edge codes.
 * assumes an 8-bit special-register port driven by the core.
 */
package irq_bank_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int NUM_SRC = 12;
    // register indices within the block's own decode window
    localparam logic [2:0] IDX_EDGE = 3'h0;
    localparam logic [2:0] IDX_CTRL0 = 3'h1;
    localparam logic [2:0] IDX_CTRL1 = 3'h2;
    localparam logic [2:0] IDX_CTRL2 = 3'h3;
    localparam logic [2:0] IDX_CTRL3 = 3'h4;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] MASK_EDGE = 8'h0f;
    localparam logic [7:0] MASK_CTRL0 = 8'h7f;
    localparam logic [7:0] MASK_CTRL3 = 8'h33;
    // edge select field positions
    localparam int POS_PIN_A_SEL = 0;
    localparam int POS_PIN_B_SEL = 2;
    // primary register 0 field positions
    localparam int POS_GLOBAL_EN = 0;
    localparam int POS_PIN_A_EN = 1;
    localparam int POS_PIN_B_EN = 2;
    localparam int POS_SERIAL_EN = 3;
    localparam int POS_PIN_A_FLAG = 4;
    localparam int POS_PIN_B_FLAG = 5;
    localparam int POS_SERIAL_FLAG = 6;
    // edge select codes
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // request vector order: src_event / irq_pending bit numbers
    localparam int SRC_PIN_A = 0;
    localparam int SRC_PIN_B = 1;
    localparam int SRC_SERIAL = 2;
    localparam int SRC_LOW_VOLTAGE = 3;
    localparam int SRC_CONVERTER = 4;
    localparam int SRC_EEPROM = 5;
    localparam int SRC_TIMEBASE_A = 6;
    localparam int SRC_TIMER_P_PERIOD = 7;
    localparam int SRC_TIMER_P_COMPARE = 8;
    localparam int SRC_TIMER_S_PERIOD = 9;
    localparam int SRC_TIMER_S_COMPARE = 10;
    localparam int SRC_ASYNC_SERIAL = 11;
    localparam int SRC_TIMEBASE_B = 12;
endpackage

/* rtl/pin_edge_detect.sv */
/*
 * one external interrupt pin: two-stage synchroniser, then edge match
 * against a two-bit select code. assumes the pin is asynchronous to clk.
 */
`timescale 1ns/10ps
module pin_edge_detect (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic pin,
    input wire logic [1:0] edge_sel,
    output logic edge_hit
);
    import irq_bank_pkg::*;

    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else if (clk_en) begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // one hit per edge: compares two settled stages only
    always_comb begin
        case (edge_sel)
            EDGE_OFF: edge_hit = 1'b0;
            EDGE_RISE: edge_hit = sync_q & ~last_q;
            EDGE_FALL: edge_hit = ~sync_q & last_q;
            EDGE_BOTH: edge_hit = sync_q ^ last_q;
            default: edge_hit = 1'b0;
        endcase
    end
endmodule

/* rtl/irq_flag_enable_bank.sv */
/*
 * interrupt request flags, individual enables, global enable and external
 * pin edge selection, reached over the core's special-register port.
 * assumes one write or read per cycle and single-cycle event pulses.
 */
`timescale 1ns/10ps
// Summary of operation
// - pin b edge select: 00 off, 01 rise, 10 fall, 11 both.
// - pin a edge select in edge register bits 1..0, same codes.
// - edge register bits 7..4 read zero, writes ignored.
// - control 0 bit 0 is global enable; zero blocks every interrupt.
// - control 0 bit 6 is serial interface flag, software writable.
// - control 0 bit 5 set by selected edge on pin b.
// - control 0 bit 4 set by selected edge on pin a.
// - control 0 bit 3 enables serial interface interrupt.
// - control 0 bit 2 enables pin b interrupt.
// - control 0 bit 1 enables pin a interrupt.
// - controls 1..3 hold peripheral flag/enable pairs, flags high nibble.
// - each source has a flag set by its event plus an enable.
// - flags still set when disabled; no request then.
// - global enable low blocks all sources.
module irq_flag_enable_bank (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [irq_bank_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [irq_bank_pkg::DATA_W-1:0] reg_wdata,
    output logic [irq_bank_pkg::DATA_W-1:0] reg_rdata,
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    input wire logic [irq_bank_pkg::NUM_SRC:0] src_event,
    output logic [irq_bank_pkg::NUM_SRC:0] irq_pending,
    output logic irq_request
);
    import irq_bank_pkg::*;

    logic rst_meta_q;
    logic rst_n;
    logic [7:0] edge_q;
    logic [7:0] ctrl0_q;
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic [7:0] ctrl3_q;
    logic [7:0] ctrl0_d;
    logic [7:0] ctrl1_d;
    logic [7:0] ctrl2_d;
    logic [7:0] ctrl3_d;
    logic hit_a;
    logic hit_b;
    logic [NUM_SRC:0] set_ev;
    logic [NUM_SRC:0] flags;
    logic [NUM_SRC:0] enables;
    logic [NUM_SRC:0] pend_d;

    // flag update: write value, then hardware sets win over a software clear
    function automatic logic [7:0] upd(input logic [7:0] cur, input logic wr,
                                      input logic [7:0] wd, input logic [7:0] mask,
                                      input logic [7:0] sets);
        logic [7:0] v;
        v = wr ? (wd & mask) : cur;
        return v | (sets & mask);
    endfunction

    // one register selected by a write strobe
    function automatic logic wr_sel(input logic wr, input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] idx);
        return wr && (addr == idx);
    endfunction

    // resetn asserts at once but releases through two flops, so no flop
    // sees the release land on its own clock edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    pin_edge_detect u_pin_a (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin(ext_irq_pin_a),
        .edge_sel(edge_q[POS_PIN_A_SEL +: 2]),
        .edge_hit(hit_a)
    );

    pin_edge_detect u_pin_b (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin(ext_irq_pin_b),
        .edge_sel(edge_q[POS_PIN_B_SEL +: 2]),
        .edge_hit(hit_b)
    );

    always_comb begin
        set_ev = src_event;
        set_ev[SRC_PIN_A] = hit_a;
        set_ev[SRC_PIN_B] = hit_b;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_q <= RST_REG;
        end else if (clk_en && wr_sel(reg_wr, reg_addr, IDX_EDGE)) begin
            edge_q <= reg_wdata & MASK_EDGE;
        end
    end

    always_comb begin
        ctrl0_d = upd(ctrl0_q, wr_sel(reg_wr, reg_addr, IDX_CTRL0), reg_wdata, MASK_CTRL0,
                      {1'b0, set_ev[SRC_SERIAL], set_ev[SRC_PIN_B], set_ev[SRC_PIN_A],
                       4'h0});
        ctrl1_d = upd(ctrl1_q, wr_sel(reg_wr, reg_addr, IDX_CTRL1), reg_wdata, 8'hff,
                      {set_ev[SRC_TIMEBASE_A], set_ev[SRC_EEPROM], set_ev[SRC_CONVERTER],
                       set_ev[SRC_LOW_VOLTAGE], 4'h0});
        ctrl2_d = upd(ctrl2_q, wr_sel(reg_wr, reg_addr, IDX_CTRL2), reg_wdata, 8'hff,
                      {set_ev[SRC_TIMER_S_COMPARE], set_ev[SRC_TIMER_S_PERIOD],
                       set_ev[SRC_TIMER_P_COMPARE], set_ev[SRC_TIMER_P_PERIOD],
                       4'h0});
        ctrl3_d = upd(ctrl3_q, wr_sel(reg_wr, reg_addr, IDX_CTRL3), reg_wdata, MASK_CTRL3,
                      {2'h0, set_ev[SRC_ASYNC_SERIAL], set_ev[SRC_TIMEBASE_B],
                       4'h0});
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0_q <= RST_REG;
            ctrl1_q <= RST_REG;
            ctrl2_q <= RST_REG;
            ctrl3_q <= RST_REG;
        end else if (clk_en) begin
            ctrl0_q <= ctrl0_d;
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            ctrl3_q <= ctrl3_d;
        end
    end

    always_comb begin
        flags = {ctrl3_q[4], ctrl3_q[5], ctrl2_q[7:4], ctrl1_q[7:4],
                 ctrl0_q[POS_SERIAL_FLAG], ctrl0_q[POS_PIN_B_FLAG],
                 ctrl0_q[POS_PIN_A_FLAG]};
        enables = {ctrl3_q[0], ctrl3_q[1], ctrl2_q[3:0], ctrl1_q[3:0],
                   ctrl0_q[POS_SERIAL_EN], ctrl0_q[POS_PIN_B_EN],
                   ctrl0_q[POS_PIN_A_EN]};
        // a flag without its enable stays visible but raises nothing
        pend_d = (flags & enables) & {(NUM_SRC + 1){ctrl0_q[POS_GLOBAL_EN]}};
    end

    // outputs one cycle behind the registers so they come straight from flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pending <= '0;
            irq_request <= 1'b0;
        end else if (clk_en) begin
            irq_pending <= pend_d;
            irq_request <= |pend_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= RST_REG;
        end else if (clk_en && reg_rd) begin
            case (reg_addr)
                IDX_EDGE: reg_rdata <= edge_q;
                IDX_CTRL0: reg_rdata <= ctrl0_q;
                IDX_CTRL1: reg_rdata <= ctrl1_q;
                IDX_CTRL2: reg_rdata <= ctrl2_q;
                IDX_CTRL3: reg_rdata <= ctrl3_q;
                default: reg_rdata <= RST_REG;
            endcase
        end
    end

    // single-cycle checks on what the bank drives; pins and events belong to the far side
    property p_global_blocks;
        @(posedge clk) disable iff (!rst_n)
        clk_en && !ctrl0_q[POS_GLOBAL_EN] |=> !irq_request;
    endproperty
    a_global_blocks: assert property (p_global_blocks)
        else $error("request raised while global enable low");

    property p_request_source;
        @(posedge clk) disable iff (!rst_n)
        $rose(irq_request) |->
            $past(ctrl0_q[POS_GLOBAL_EN]) && $past(|(flags & enables));
    endproperty
    a_request_source: assert property (p_request_source)
        else $error("request without enabled flag");

    property p_pin_a_sets;
        @(posedge clk) disable iff (!rst_n)
        clk_en && hit_a |=> ctrl0_q[POS_PIN_A_FLAG];
    endproperty
    a_pin_a_sets: assert property (p_pin_a_sets)
        else $error("pin a edge lost");

    property p_pin_b_sets;
        @(posedge clk) disable iff (!rst_n)
        clk_en && hit_b |=> ctrl0_q[POS_PIN_B_FLAG];
    endproperty
    a_pin_b_sets: assert property (p_pin_b_sets)
        else $error("pin b edge lost");

    property p_edge_upper_zero;
        @(posedge clk) disable iff (!rst_n)
        edge_q[7:4] == 4'h0;
    endproperty
    a_edge_upper_zero: assert property (p_edge_upper_zero)
        else $error("edge register upper bits set");

    property p_pin_a_off;
        @(posedge clk) disable iff (!rst_n)
        clk_en && edge_q[POS_PIN_A_SEL +: 2] == EDGE_OFF && !ctrl0_q[POS_PIN_A_FLAG] &&
            !wr_sel(reg_wr, reg_addr, IDX_CTRL0) |=> !ctrl0_q[POS_PIN_A_FLAG];
    endproperty
    a_pin_a_off: assert property (p_pin_a_off)
        else $error("disabled pin a set its flag");

    property p_flag_without_enable;
        @(posedge clk) disable iff (!rst_n)
        clk_en && src_event[SRC_CONVERTER] |=> ctrl1_q[5];
    endproperty
    a_flag_without_enable: assert property (p_flag_without_enable)
        else $error("converter flag not set");

    property p_disabled_no_pend;
        @(posedge clk) disable iff (!rst_n)
        clk_en && !ctrl0_q[POS_SERIAL_EN] |=> !irq_pending[SRC_SERIAL];
    endproperty
    a_disabled_no_pend: assert property (p_disabled_no_pend)
        else $error("disabled serial source pending");

    property p_serial_sets;
        @(posedge clk) disable iff (!rst_n)
        clk_en && src_event[SRC_SERIAL] |=> ctrl0_q[POS_SERIAL_FLAG];
    endproperty
    a_serial_sets: assert property (p_serial_sets)
        else $error("serial flag not set");

    property p_pin_b_off;
        @(posedge clk) disable iff (!rst_n)
        clk_en && edge_q[POS_PIN_B_SEL +: 2] == EDGE_OFF && !ctrl0_q[POS_PIN_B_FLAG] &&
            !wr_sel(reg_wr, reg_addr, IDX_CTRL0) |=> !ctrl0_q[POS_PIN_B_FLAG];
    endproperty
    a_pin_b_off: assert property (p_pin_b_off)
        else $error("disabled pin b set its flag");

    property p_edge_read_upper;
        @(posedge clk) disable iff (!rst_n)
        clk_en && reg_rd && reg_addr == IDX_EDGE |=> reg_rdata[7:4] == 4'h0;
    endproperty
    a_edge_read_upper: assert property (p_edge_read_upper)
        else $error("edge register read upper bits set");

    property p_ctrl3_read_unused;
        @(posedge clk) disable iff (!rst_n)
        clk_en && reg_rd && reg_addr == IDX_CTRL3 |=> (reg_rdata & ~MASK_CTRL3) == 8'h00;
    endproperty
    a_ctrl3_read_unused: assert property (p_ctrl3_read_unused)
        else $error("control 3 unused bits read set");

    property p_timebase_b_sets;
        @(posedge clk) disable iff (!rst_n)
        clk_en && src_event[SRC_TIMEBASE_B] |=> ctrl3_q[4];
    endproperty
    a_timebase_b_sets: assert property (p_timebase_b_sets)
        else $error("time base b flag not set");

    property p_pin_a_single;
        @(posedge clk) disable iff (!rst_n)
        clk_en && hit_a && edge_q[POS_PIN_A_SEL +: 2] != EDGE_BOTH &&
            !wr_sel(reg_wr, reg_addr, IDX_EDGE) |=> !hit_a;
    endproperty
    a_pin_a_single: assert property (p_pin_a_single)
        else $error("pin a edge detected twice");

    property p_edge_write_lands;
        @(posedge clk) disable iff (!rst_n)
        clk_en && wr_sel(reg_wr, reg_addr, IDX_EDGE) |=>
            edge_q[POS_PIN_A_SEL +: 2] == $past(reg_wdata[POS_PIN_A_SEL +: 2]) &&
            edge_q[POS_PIN_B_SEL +: 2] == $past(reg_wdata[POS_PIN_B_SEL +: 2]);
    endproperty
    a_edge_write_lands: assert property (p_edge_write_lands)
        else $error("edge select write lost");

    property p_frozen;
        @(posedge clk) disable iff (!rst_n)
        !clk_en |=> $stable(ctrl0_q) && $stable(edge_q) && $stable(irq_pending);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("state moved while clock enable low");

    // scenarios the bench is expected to reach
    c_pin_a: cover property (@(posedge clk) disable iff (!rst_n) hit_a);
    c_request: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq_request));
    c_masked_flag: cover property (@(posedge clk) disable iff (!rst_n)
        |flags && !ctrl0_q[POS_GLOBAL_EN]);
    c_pin_b_fall: cover property (@(posedge clk) disable iff (!rst_n)
        hit_b && edge_q[POS_PIN_B_SEL +: 2] == EDGE_FALL);
    c_frozen: cover property (@(posedge clk) disable iff (!rst_n)
        !clk_en && reg_wr);
endmodule

/* tb/periph_event_model.sv */
/*
 * stand-in for the peripheral event sources and the two external pins.
 * assumes the bench asks for events through fire, changed just after an edge.
 */
`timescale 1ns/10ps
module periph_event_model (
    input wire logic clk,
    input wire logic [12:0] fire,
    input wire logic pin_a_lvl,
    input wire logic pin_b_lvl,
    output logic [12:0] src_event,
    output logic ext_irq_pin_a,
    output logic ext_irq_pin_b
);
    // each request passes through one flop, one cycle late, and lasts as long as fire is held
    always_ff @(posedge clk) begin
        src_event <= fire;
    end
    // pins are asynchronous to clk: change them mid-cycle on purpose
    assign #1.3 ext_irq_pin_a = pin_a_lvl;
    assign #1.3 ext_irq_pin_b = pin_b_lvl;
endmodule

/* tb/test_irq_flag_enable_bank.sv */
/*
 * self-checking bench for the interrupt flag and enable bank.
 * assumes the register port and latencies given in the design hand-over.
 */
`timescale 1ns/10ps
module test_irq_flag_enable_bank;
    import irq_bank_pkg::*;
    logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, pa = 0, pb = 0, pin_a, pin_b, req;
    logic [ADDR_W-1:0] reg_addr = 3'h0;
    logic [DATA_W-1:0] reg_wdata = 8'h00, reg_rdata;
    logic [NUM_SRC:0] fire = 13'h0000, src_event, pend;
    int n_errors = 0, tests_run = 0;
    logic ce = 1;
    // where each source's flag lives, in package source order
    logic [2:0] freg [13] = '{1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 4};
    int fbit [13] = '{4, 5, 6, 4, 5, 6, 7, 4, 5, 6, 7, 5, 4};
    logic [7:0] en [5] = '{8'h00, 8'h09, 8'h0f, 8'h0f, 8'h03};
    periph_event_model peer (.clk(clk), .fire(fire), .pin_a_lvl(pa), .pin_b_lvl(pb),
        .src_event(src_event), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b));
    irq_flag_enable_bank DUT (.clk(clk), .resetn(resetn), .clk_en(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b), .src_event(src_event),
        .irq_pending(pend), .irq_request(req));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk13(input logic [12:0] got, input logic [12:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: pending %h expected %h", $time, got, exp);
        end
    endtask
    // an idle cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(posedge clk);
        #1 reg_wr = 0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1;
        @(posedge clk);
        #1 reg_rd = 0;
        chk8(reg_rdata, exp);
        @(posedge clk);
        #1;
    endtask
    task automatic pulse(input int i);
        fire[i] = 1;
        @(posedge clk);
        #1 fire = 13'h0000;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic t_masks;
        logic [7:0] m [5] = '{MASK_EDGE, MASK_CTRL0, 8'hff, 8'hff, MASK_CTRL3};
        for (int a = 0; a < 5; a++) begin
            rd(a[2:0], 8'h00);
            wr(a[2:0], 8'hff);
            rd(a[2:0], m[a]);
            wr(a[2:0], 8'h00);
        end
        wr(3'h5, 8'hff);
        rd(3'h5, 8'h00);
    endtask
    task automatic t_sources;
        for (int r = 1; r < 5; r++) wr(r[2:0], en[r]);
        pulse(SRC_PIN_A);
        rd(IDX_CTRL0, 8'h09);
        for (int i = 2; i <= NUM_SRC; i++) begin
            pulse(i);
            chk13(pend, 13'h0001 << i);
            chk8({7'h00, req}, 8'h01);
            rd(freg[i], en[freg[i]] | (8'h01 << fbit[i]));
            wr(freg[i], en[freg[i]]);
        end
    endtask
    task automatic t_global;
        wr(IDX_CTRL0, 8'h08);
        pulse(SRC_SERIAL);
        chk13(pend, 13'h0000);
        rd(IDX_CTRL0, 8'h48);
        wr(IDX_CTRL0, 8'h49);
        chk13(pend, 13'h0004);
        wr(IDX_CTRL0, 8'h41);
        chk8({7'h00, req}, 8'h00);
        wr(IDX_CTRL0, 8'h00);
    endtask
    task automatic t_pins;
        logic [7:0] f;
        for (int p = 0; p < 2; p++) begin
            f = 8'h10 << p;
            for (int c = 0; c < 4; c++) begin
                wr(IDX_EDGE, 8'(c << (2 * p)));
                wr(IDX_CTRL0, 8'h07);
                if (p == 0) pa = 1; else pb = 1;
                repeat (6) @(posedge clk);
                #1 chk13(pend, c[0] ? 13'h0001 << p : 13'h0000);
                rd(IDX_CTRL0, c[0] ? 8'h07 | f : 8'h07);
                wr(IDX_CTRL0, 8'h07);
                if (p == 0) pa = 0; else pb = 0;
                repeat (6) @(posedge clk);
                #1 rd(IDX_CTRL0, c[1] ? 8'h07 | f : 8'h07);
                wr(IDX_CTRL0, 8'h00);
            end
        end
    endtask
    task automatic t_freeze;
        ce = 0;
        wr(IDX_CTRL0, 8'h49);
        pulse(SRC_SERIAL);
        ce = 1;
        chk13(pend, 13'h0000);
        rd(IDX_CTRL0, 8'h00);
    endtask
    task automatic finish_test;
        $display("Mismatches %0d in %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        $display("Error at %0t: run overran its bound", $time);
        finish_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 resetn = 1;
        repeat (4) @(posedge clk);
        #1 chk8({7'h00, req}, 8'h00);
        t_masks();
        t_sources();
        t_global();
        t_pins();
        t_freeze();
        finish_test();
    end
endmodule
